// [hw/wake_ctrl_pkg.sv]
package wake_ctrl_pkg;

  // register port geometry
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [2:0] OFS_SEL_ONE = 3'h0;
  localparam logic [2:0] OFS_SEL_TWO = 3'h1;
  localparam logic [2:0] OFS_PCKEN_ONE = 3'h2;
  localparam logic [2:0] OFS_PCKEN_TWO = 3'h3;
  localparam logic [2:0] OFS_PCKEN_THREE = 3'h4;
  localparam logic [2:0] OFS_GLOBAL_CFG = 3'h5;
  localparam logic [2:0] OFS_STATUS = 3'h6;

  // reset values
  localparam logic [7:0] RST_SEL_ONE = 8'h00;
  localparam logic [7:0] RST_SEL_TWO = 8'h00;
  localparam logic [7:0] RST_PCKEN = 8'h00;
  localparam logic [7:0] RST_GLOBAL_CFG = 8'h00;

  // field positions
  localparam int GCFG_ACTIVATION_LEVEL = 0;
  localparam int STAT_EVENT_PEND = 3;
  localparam int STAT_IRQ_PEND = 4;

  // condition code level that blocks all maskable interrupts
  localparam logic [1:0] LEVEL_ALL_MASKED = 2'h3;

  // cpu power states
  typedef enum logic [2:0] {
    ST_RUN,
    ST_WAIT_IRQ,
    ST_WAIT_EVENT,
    ST_SERVE_FROM_IRQ_WAIT,
    ST_SERVE_FROM_EVENT_WAIT
  } cpu_state_t;

endpackage

// [hw/wait_mode_wakeup_event_ctrl.sv]
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
// How it works
// - software gates each peripheral clock, always
// - wait instruction stops cpu clock only
// - wait keeps registers untouched
// - any interrupt not masked by condition code level restarts cpu from interrupt-wait
// - activation level returns to interrupt-wait
// - event-wait interrupts obey condition code level
// - event-enabled sources never raise interrupts
// - serviced interrupt returns to event-wait
// - wakeup event resumes after wait instruction
// - select one bits 7:4 pins 3:0
// - select one bits 3:2 advanced timer
// - select one bits 1:0 second timer
// - select two bits 3:0 pins 7:4
// - select two bit 7 converter, comparators
// - select two bit 6 ports E,F
// - select two bit 5 port D,H
// - select two bit 4 port B,G

module wait_mode_wakeup_event_ctrl
  import wake_ctrl_pkg::*;
#(
  parameter bit MEDIUM_DENSITY = 1'h0
)
(
  input wire logic clock_i,
  input wire logic rst_i,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  // cpu side
  input wire logic wait_for_interrupt_instr_i,
  input wire logic wait_for_event_instr_i,
  input wire logic irq_return_i,
  input wire logic int_level_bit_low_i,
  input wire logic int_level_bit_high_i,
  output logic cpu_clock_en_o,
  output logic irq_request_o,
  output logic event_resume_o,
  output logic skip_context_restore_o,
  output logic wait_mode_o,
  // interrupt sources
  input wire logic [7:0] pin_irq_i,
  input wire logic port_b_irq_i,
  input wire logic port_g_irq_i,
  input wire logic port_d_irq_i,
  input wire logic port_h_irq_i,
  input wire logic port_e_irq_i,
  input wire logic port_f_irq_i,
  input wire logic adv_timer_capcmp_irq_i,
  input wire logic adv_timer_update_irq_i,
  input wire logic timer_b_capcmp_irq_i,
  input wire logic timer_b_update_irq_i,
  input wire logic converter_comparator_irq_i,
  input wire logic [7:0] other_irq_i,
  // peripheral clock gates
  output logic [7:0] periph_clock_enable_one_o,
  output logic [7:0] periph_clock_enable_two_o,
  output logic [7:0] periph_clock_enable_three_o
);

  ////////////////////////////////////////////////////////////////////////////
  // registers and state

  logic [7:0] wakeup_event_select_one;
  logic [7:0] wakeup_event_select_two;
  logic [7:0] periph_clock_enable_one;
  logic [7:0] periph_clock_enable_two;
  logic [7:0] periph_clock_enable_three;
  logic [7:0] global_config_register;
  cpu_state_t state;
  cpu_state_t next_state;

  logic [7:0] src_one;
  logic [7:0] src_two;
  logic event_hit;
  logic irq_pending;
  logic irq_allowed;
  logic activation_level;
  logic in_wait;
  logic resume_now;

  assign activation_level = global_config_register[GCFG_ACTIVATION_LEVEL];

  ////////////////////////////////////////////////////////////////////////////
  // source vectors, laid out like the select registers

  assign src_one = {pin_irq_i[3:0],
                    adv_timer_capcmp_irq_i,
                    adv_timer_update_irq_i,
                    timer_b_capcmp_irq_i,
                    timer_b_update_irq_i};

  // converter and comparators on bit 7
  // ports E and F on bit 6
  // port D, port H except medium density
  // port B, port G except medium density
  assign src_two = {converter_comparator_irq_i,
                    port_e_irq_i | port_f_irq_i,
                    port_d_irq_i | (port_h_irq_i & ~MEDIUM_DENSITY),
                    port_b_irq_i | (port_g_irq_i & ~MEDIUM_DENSITY),
                    pin_irq_i[7:4]};

  // one wakeup request from any enabled source
  // level sensitive: a source held high keeps waking
  assign event_hit = |(src_one & wakeup_event_select_one) |
                     |(src_two & wakeup_event_select_two);

  // event-enabled sources are kept off the interrupt path
  assign irq_pending = |(src_one & ~wakeup_event_select_one) |
                       |(src_two & ~wakeup_event_select_two) |
                       |other_irq_i;

  // condition code level gates interrupt service
  assign irq_allowed = irq_pending &
    ({int_level_bit_high_i, int_level_bit_low_i} != LEVEL_ALL_MASKED);

  ////////////////////////////////////////////////////////////////////////////
  // power state machine

  always_comb
  begin
    next_state = state;
    case (state)
      ST_RUN:
      begin
        // either wait instruction stops the cpu
        if (wait_for_interrupt_instr_i)
          next_state = ST_WAIT_IRQ;
        else if (wait_for_event_instr_i)
          next_state = ST_WAIT_EVENT;
      end
      ST_WAIT_IRQ:
      begin
        if (irq_allowed)
          next_state = ST_SERVE_FROM_IRQ_WAIT;
      end
      ST_WAIT_EVENT:
      begin
        // event wins, resume after the instruction
        if (event_hit)
          next_state = ST_RUN;
        else if (irq_allowed)
          next_state = ST_SERVE_FROM_EVENT_WAIT;
      end
      ST_SERVE_FROM_IRQ_WAIT:
      begin
        // activation level sends cpu back to wait
        if (irq_return_i)
          next_state = activation_level ? ST_WAIT_IRQ : ST_RUN;
      end
      ST_SERVE_FROM_EVENT_WAIT:
      begin
        // back to event wait after service
        if (irq_return_i)
          next_state = ST_WAIT_EVENT;
      end
      // unused state codes fall back to run
      default:
      begin
        next_state = ST_RUN;
      end
    endcase
  end

  // state register
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      state <= ST_RUN;
    else
      state <= next_state;
  end

  // outputs register the next state, so they change with the state
  assign in_wait = (next_state == ST_WAIT_IRQ) ||
                   (next_state == ST_WAIT_EVENT);
  assign resume_now = (state == ST_WAIT_EVENT) && event_hit;

  ////////////////////////////////////////////////////////////////////////////
  // cpu outputs

  // cpu clock off while waiting, peripherals untouched
  // the peripheral gates are deliberately not touched here
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cpu_clock_en_o <= 1'h1;
      wait_mode_o <= 1'h0;
    end
    else
    begin
      cpu_clock_en_o <= ~in_wait;
      wait_mode_o <= in_wait;
    end
  end

  // interrupt request to the core
  // an event resume must not also start a service routine
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      irq_request_o <= 1'h0;
    else if (state == ST_WAIT_EVENT && event_hit)
      irq_request_o <= 1'h0;
    else
      irq_request_o <= irq_allowed;
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      event_resume_o <= 1'h0;
    else
      event_resume_o <= resume_now;
  end

  // tell core not to restore main context
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      skip_context_restore_o <= 1'h0;
    else
      skip_context_restore_o <= (state == ST_SERVE_FROM_IRQ_WAIT) &&
                                irq_return_i && activation_level;
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes

  // nothing here reacts to wait entry, contents stay
  // event selects clear on reset, read-write
  // second select clears on reset, read-write
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wakeup_event_select_one <= RST_SEL_ONE;
      wakeup_event_select_two <= RST_SEL_TWO;
    end
    else if (reg_write_i)
    begin
      if (reg_addr_i == OFS_SEL_ONE)
        wakeup_event_select_one <= reg_wdata_i;
      else if (reg_addr_i == OFS_SEL_TWO)
        wakeup_event_select_two <= reg_wdata_i;
    end
  end

  // clock gates writable at any time, in any mode
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      periph_clock_enable_one <= RST_PCKEN;
      periph_clock_enable_two <= RST_PCKEN;
      periph_clock_enable_three <= RST_PCKEN;
    end
    else if (reg_write_i)
    begin
      if (reg_addr_i == OFS_PCKEN_ONE)
        periph_clock_enable_one <= reg_wdata_i;
      else if (reg_addr_i == OFS_PCKEN_TWO)
        periph_clock_enable_two <= reg_wdata_i;
      else if (reg_addr_i == OFS_PCKEN_THREE)
        periph_clock_enable_three <= reg_wdata_i;
    end
  end

  // global configuration, activation level in bit 0
  // upper bits are not stored and read back as zero
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      global_config_register <= RST_GLOBAL_CFG;
    else if (reg_write_i && reg_addr_i == OFS_GLOBAL_CFG)
      global_config_register <= {7'h00, reg_wdata_i[GCFG_ACTIVATION_LEVEL]};
  end

  // gate outputs follow the registers one cycle later
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      periph_clock_enable_one_o <= RST_PCKEN;
      periph_clock_enable_two_o <= RST_PCKEN;
      periph_clock_enable_three_o <= RST_PCKEN;
    end
    else
    begin
      periph_clock_enable_one_o <= periph_clock_enable_one;
      periph_clock_enable_two_o <= periph_clock_enable_two;
      periph_clock_enable_three_o <= periph_clock_enable_three;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads, data in the cycle after the strobe

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      reg_rdata_o <= 8'h00;
    else if (reg_read_i)
    begin
      if (reg_addr_i == OFS_SEL_ONE)
        reg_rdata_o <= wakeup_event_select_one;
      else if (reg_addr_i == OFS_SEL_TWO)
        reg_rdata_o <= wakeup_event_select_two;
      else if (reg_addr_i == OFS_PCKEN_ONE)
        reg_rdata_o <= periph_clock_enable_one;
      else if (reg_addr_i == OFS_PCKEN_TWO)
        reg_rdata_o <= periph_clock_enable_two;
      else if (reg_addr_i == OFS_PCKEN_THREE)
        reg_rdata_o <= periph_clock_enable_three;
      else if (reg_addr_i == OFS_GLOBAL_CFG)
        reg_rdata_o <= global_config_register;
      // status: pending interrupt, event hit, state code
      else if (reg_addr_i == OFS_STATUS)
        reg_rdata_o <= {3'h0, irq_pending, event_hit, state};
      else
        reg_rdata_o <= 8'h00; // unmapped reads zero
    end
    else
      reg_rdata_o <= 8'h00;
  end

endmodule

// [test/wake_ctrl_sva.sv]
`timescale 1ns/10ps
module wake_ctrl_sva
  import wake_ctrl_pkg::*;
(
  input logic clock_i,
  input logic rst_i,
  input logic reg_read_i,
  input logic [DATA_W-1:0] reg_rdata_o,
  input logic wait_for_interrupt_instr_i,
  input logic wait_for_event_instr_i,
  input logic irq_return_i,
  input logic int_level_bit_low_i,
  input logic int_level_bit_high_i,
  input logic cpu_clock_en_o,
  input logic irq_request_o,
  input logic event_resume_o,
  input logic skip_context_restore_o,
  input logic wait_mode_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////
  // a wait instruction taken while the cpu runs freely
  sequence s_enter;
    (wait_for_interrupt_instr_i || wait_for_event_instr_i) &&
      cpu_clock_en_o && !irq_request_o;
  endsequence
  a_wait_entry: assert property (s_enter |=> !cpu_clock_en_o)
    else $error("wait entry kept cpu clock");
  a_mode_inverse: assert property (wait_mode_o == !cpu_clock_en_o)
    else $error("wait flag disagrees with cpu clock");
  a_resume_once: assert property (event_resume_o |=> !event_resume_o)
    else $error("resume pulse too long");
  a_resume_cause: assert property (event_resume_o |->
    $past(wait_mode_o) && cpu_clock_en_o && !irq_request_o)
    else $error("resume without wait or with service");
  a_level_block: assert property (
    (int_level_bit_high_i && int_level_bit_low_i) [*2] |-> !irq_request_o)
    else $error("interrupt passed full mask level");
  a_read_idle: assert property (!$past(reg_read_i) |-> reg_rdata_o == '0)
    else $error("read data outside its cycle");
  a_level_return: assert property (skip_context_restore_o |->
    $past(irq_return_i) ##[0:1] wait_mode_o)
    else $error("activation return not back in wait");
  a_wake_cause: assert property ($fell(wait_mode_o) |->
    irq_request_o || event_resume_o)
    else $error("wake without cause");
endmodule
bind wait_mode_wakeup_event_ctrl wake_ctrl_sva wake_ctrl_sva_i (
  .clock_i(clock_i),
  .rst_i(rst_i),
  .reg_read_i(reg_read_i),
  .reg_rdata_o(reg_rdata_o),
  .wait_for_interrupt_instr_i(wait_for_interrupt_instr_i),
  .wait_for_event_instr_i(wait_for_event_instr_i),
  .irq_return_i(irq_return_i),
  .int_level_bit_low_i(int_level_bit_low_i),
  .int_level_bit_high_i(int_level_bit_high_i),
  .cpu_clock_en_o(cpu_clock_en_o),
  .irq_request_o(irq_request_o),
  .event_resume_o(event_resume_o),
  .skip_context_restore_o(skip_context_restore_o),
  .wait_mode_o(wait_mode_o)
);

// [test/cpu_model.sv]
`timescale 1ns/10ps
module cpu_model (
  input logic clock_i,
  input logic rst_i,
  input logic irq_request_o,
  input logic [3:0] dly_i,
  output logic irq_return_i
);
  logic [3:0] cnt;
  logic busy;
  ////////////////////////////////////////////////////////////////
  // serve a request for dly_i + 1 cycles, then end the routine
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      busy <= 1'h0;
      cnt <= 4'h0;
      irq_return_i <= 1'h0;
    end
    else
    begin
      irq_return_i <= 1'h0;
      if (!busy)
      begin
        busy <= irq_request_o;
        cnt <= dly_i;
      end
      else if (cnt == 4'h0)
      begin
        busy <= 1'h0;
        irq_return_i <= 1'h1;
      end
      else
        cnt <= cnt - 4'h1;
    end
  end
endmodule

// [test/tb_top.sv]
`timescale 1ns/10ps
module tb_top
  import wake_ctrl_pkg::*;
;
  logic clock_i, rst_i, reg_write_i, reg_read_i, irq_return_i;
  logic wait_for_interrupt_instr_i, wait_for_event_instr_i;
  logic int_level_bit_low_i, int_level_bit_high_i, cpu_clock_en_o;
  logic irq_request_o, event_resume_o, skip_context_restore_o, wait_mode_o;
  logic [2:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, other_irq_i;
  logic [7:0] periph_clock_enable_one_o, periph_clock_enable_two_o;
  logic [7:0] periph_clock_enable_three_o;
  logic [15:0] src, sel;
  logic [3:0] dly_i;
  int failures, checks, i;
  // sources in select-register bit order, register two on top
  wire logic [7:0] pin_irq_i = {src[11:8], src[7:4]};
  logic alt; // picks the second member of each port pair
  wire logic port_b_irq_i = src[12] & !alt, port_g_irq_i = src[12] & alt;
  wire logic port_d_irq_i = src[13] & !alt, port_h_irq_i = src[13] & alt;
  wire logic port_e_irq_i = src[14] & !alt, port_f_irq_i = src[14] & alt;
  wire logic converter_comparator_irq_i = src[15];
  wire logic adv_timer_capcmp_irq_i = src[3], adv_timer_update_irq_i = src[2];
  wire logic timer_b_capcmp_irq_i = src[1], timer_b_update_irq_i = src[0];
  wire logic [3:0] obs = {skip_context_restore_o, wait_mode_o, irq_request_o,
    event_resume_o};
  ////////////////////////////////////////////////////////////////
  wait_mode_wakeup_event_ctrl wait_mode_wakeup_event_ctrl_i (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_write_i(reg_write_i),
    .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o),
    .wait_for_interrupt_instr_i(wait_for_interrupt_instr_i),
    .wait_for_event_instr_i(wait_for_event_instr_i),
    .irq_return_i(irq_return_i),
    .int_level_bit_low_i(int_level_bit_low_i),
    .int_level_bit_high_i(int_level_bit_high_i),
    .cpu_clock_en_o(cpu_clock_en_o),
    .irq_request_o(irq_request_o),
    .event_resume_o(event_resume_o),
    .skip_context_restore_o(skip_context_restore_o),
    .wait_mode_o(wait_mode_o),
    .pin_irq_i(pin_irq_i),
    .port_b_irq_i(port_b_irq_i),
    .port_g_irq_i(port_g_irq_i),
    .port_d_irq_i(port_d_irq_i),
    .port_h_irq_i(port_h_irq_i),
    .port_e_irq_i(port_e_irq_i),
    .port_f_irq_i(port_f_irq_i),
    .adv_timer_capcmp_irq_i(adv_timer_capcmp_irq_i),
    .adv_timer_update_irq_i(adv_timer_update_irq_i),
    .timer_b_capcmp_irq_i(timer_b_capcmp_irq_i),
    .timer_b_update_irq_i(timer_b_update_irq_i),
    .converter_comparator_irq_i(converter_comparator_irq_i),
    .other_irq_i(other_irq_i),
    .periph_clock_enable_one_o(periph_clock_enable_one_o),
    .periph_clock_enable_two_o(periph_clock_enable_two_o),
    .periph_clock_enable_three_o(periph_clock_enable_three_o)
  );
  cpu_model cpu_model_i (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .irq_request_o(irq_request_o),
    .dly_i(dly_i),
    .irq_return_i(irq_return_i)
  );
  // free-running system clock
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  ////////////////////////////////////////////////////////////////
  // counts, verdict and end of run
  task automatic summarize();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // compare one value and report a mismatch
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one register access: write when w is set, else read and compare
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_write_i <= w;
    reg_read_i <= !w;
    @(posedge clock_i);
    reg_write_i <= 1'b0;
    reg_read_i <= 1'b0;
    #1;
    if (!w)
      chk(reg_rdata_o, d);
  endtask
  // one-cycle wait instruction: 1 interrupt-wait, 0 event-wait
  task automatic pul(input logic k);
    @(posedge clock_i);
    wait_for_interrupt_instr_i <= k;
    wait_for_event_instr_i <= !k;
    @(posedge clock_i);
    wait_for_interrupt_instr_i <= 1'b0;
    wait_for_event_instr_i <= 1'b0;
  endtask
  // set the interrupt sources at a clock edge
  task automatic drv(input logic [15:0] s, input logic [7:0] o);
    @(posedge clock_i);
    src <= s;
    other_irq_i <= o;
  endtask
  // set the condition code level at a clock edge
  task automatic lvl(input logic [1:0] v);
    @(posedge clock_i);
    {int_level_bit_high_i, int_level_bit_low_i} <= v;
  endtask
  // poll one observed output for at most 20 cycles
  task automatic wfor(input int k, input logic v);
    int n;
    n = 0;
    do
    begin
      @(posedge clock_i);
      #1;
      n++;
    end
    while (obs[k] !== v && n < 20);
    chk(obs[k], v);
    if (obs[k] !== v)
      summarize();
  endtask
  ////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    rst_i = 1'b1;
    {reg_write_i, reg_read_i, wait_for_interrupt_instr_i} = '0;
    {wait_for_event_instr_i, int_level_bit_low_i, int_level_bit_high_i} = '0;
    {reg_addr_i, reg_wdata_i, other_irq_i, src, sel} = '0;
    dly_i = 4'h1;
    alt = 1'h0;
    failures = 0;
    checks = 0;
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    acc(1'b0, OFS_SEL_ONE, 8'h00);
    acc(1'b0, OFS_SEL_TWO, 8'h00);
    acc(1'b1, OFS_SEL_ONE, 8'hA5);
    acc(1'b0, OFS_SEL_ONE, 8'hA5);
    acc(1'b1, OFS_SEL_TWO, 8'h5A);
    acc(1'b0, OFS_SEL_TWO, 8'h5A);
    acc(1'b0, 3'h7, 8'h00);
    for (i = 0; i < 3; i++)
    begin
      acc(1'h1, OFS_PCKEN_ONE + 3'(i), 8'h81 >> i);
      acc(1'h0, OFS_PCKEN_ONE + 3'(i), 8'h81 >> i);
    end
    repeat (2) @(posedge clock_i);
    #1;
    chk({periph_clock_enable_one_o, periph_clock_enable_two_o,
      periph_clock_enable_three_o}, 24'h814020);
    $display("registers done");
    drv(16'h0000, 8'h00);
    {int_level_bit_high_i, int_level_bit_low_i} <= 2'h3;
    // the last three passes drive the other member of each port pair
    for (i = 0; i < 19; i++)
    begin
      alt = (i > 15);
      sel = 16'h0001 << (i > 15 ? i - 4 : i);
      acc(1'b1, OFS_SEL_ONE, sel[7:0]);
      acc(1'b1, OFS_SEL_TWO, sel[15:8]);
      pul(1'b0);
      wfor(2, 1'b1);
      acc(1'b0, OFS_SEL_TWO, sel[15:8]);
      chk({periph_clock_enable_one_o, periph_clock_enable_two_o,
        periph_clock_enable_three_o}, 24'h814020);
      drv({sel[14:0], sel[15]}, 8'h00);
      repeat (3) @(posedge clock_i);
      #1;
      chk({wait_mode_o, irq_request_o}, 2'b10);
      drv(sel, 8'h00);
      wfor(0, 1'b1);
      chk(irq_request_o, 1'b0);
      // unmasked, the event-enabled source must still not interrupt
      lvl(2'h0);
      repeat (2) @(posedge clock_i);
      #1;
      chk(irq_request_o, 1'h0);
      drv(16'h0000, 8'h00);
      lvl(2'h3);
    end
    $display("wakeup event table done");
    acc(1'b1, OFS_SEL_ONE, 8'h00);
    acc(1'b1, OFS_SEL_TWO, 8'h00);
    drv(16'h0000, 8'h00);
    {int_level_bit_high_i, int_level_bit_low_i} <= 2'h0;
    for (i = 0; i < 2; i++)
    begin
      acc(1'b1, OFS_GLOBAL_CFG, 8'(i));
      pul(1'b1);
      wfor(2, 1'b1);
      drv(16'h0000, 8'h01);
      dly_i <= i ? 4'h6 : 4'h1;
      wfor(1, 1'b1);
      chk(cpu_clock_en_o, 1'b1);
      // software clears the source flag during service
      drv(16'h0000, 8'h00);
      if (i == 1)
      begin
        wfor(3, 1'b1);
        wfor(2, 1'b1);
        acc(1'b0, OFS_GLOBAL_CFG, 8'h01);
        acc(1'b1, OFS_GLOBAL_CFG, 8'h00);
        drv(16'h0000, 8'h80);
        wfor(1, 1'b1);
        drv(16'h0000, 8'h00);
      end
      repeat (12) @(posedge clock_i);
      #1;
      chk(wait_mode_o, 1'b0);
    end
    $display("interrupt wait done");
    pul(1'b0);
    wfor(2, 1'b1);
    drv(16'h0000, 8'h02);
    wfor(1, 1'b1);
    drv(16'h0000, 8'h00);
    wfor(2, 1'b1);
    acc(1'b0, OFS_STATUS, 8'h02);
    $display("event wait interrupt done");
    summarize();
  end
endmodule
